/* File: common/lkbd_pkg.sv */
package lkbd_pkg;

    // Register window offset of the emulation control register, in bytes.
    localparam logic [11:0] LKBD_CTRL_OFFSET   = 12'h100;
    // Width of the operational register offset bus.
    localparam int          LKBD_ADDR_W        = 12;
    // Reset value of the emulation control register.
    localparam logic [31:0] LKBD_CTRL_RESET    = 32'h0000_0000;

    // Bit positions inside the emulation control register.
    localparam int LKBD_BIT_EMUL_EN     = 0;
    localparam int LKBD_BIT_EMUL_INT    = 1;
    localparam int LKBD_BIT_CHAR_PEND   = 2;
    localparam int LKBD_BIT_OUT_IRQ_EN  = 3;
    localparam int LKBD_BIT_EXT_IRQ_EN  = 4;
    localparam int LKBD_BIT_A20_SEQ     = 5;
    localparam int LKBD_BIT_KBD_ACTIVE  = 6;
    localparam int LKBD_BIT_MOUSE_ACT   = 7;
    localparam int LKBD_BIT_A20_STATE   = 8;

    // Legacy I/O port addresses that are decoded while emulation is on.
    localparam logic [15:0] LKBD_PORT_DATA     = 16'h0060;
    localparam logic [15:0] LKBD_PORT_CMD      = 16'h0064;
    // Command byte that opens the gate A20 sequence.
    localparam logic [7:0]  LKBD_CMD_GATE_A20  = 8'hd1;
    // Bit of the data byte that carries the requested gate A20 level.
    localparam int          LKBD_A20_DATA_BIT  = 1;

    // Number of synchronised keyboard controller request lines.
    localparam int          LKBD_NUM_IRQ       = 2;
    // Index of each request line in the synchronised vector.
    localparam int          LKBD_IDX_KBD       = 0;
    localparam int          LKBD_IDX_MOUSE     = 1;

endpackage : lkbd_pkg

/* File: logic/lkbd_sync.sv */
`timescale 1ns/10ps
// Two flip-flop synchroniser for request lines that arrive from the keyboard controller.
module lkbd_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             mclk_in,     // Host controller clock.
    input  wire logic             reset_n_in,  // Synchronous reset, active low.
    input  wire logic [WIDTH-1:0] async_in,    // Asynchronous request levels.
    output logic      [WIDTH-1:0] sync_out     // Synchronised request levels.
);

    logic [WIDTH-1:0] stage_one;  // First stage, read only by the second stage.
    logic [WIDTH-1:0] stage_two;  // Second stage, safe for logic to read.

    // Both stages shift every clock; reset drives them to the idle level.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            stage_one <= '0;
            stage_two <= '0;
        end else begin
            stage_one <= async_in;
            stage_two <= stage_one;
        end
    end

    // The output is the second stage itself.
    assign sync_out = stage_two;

endmodule : lkbd_sync

/* File: logic/lkbd_ctrl.sv */
`timescale 1ns/10ps
module lkbd_ctrl (
    input  wire logic                            mclk_in,           // Host controller clock, 20 MHz.
    input  wire logic                            reset_n_in,        // Synchronous reset, active low.
    // Memory-mapped operational register path.
    input  wire logic [lkbd_pkg::LKBD_ADDR_W-1:0] reg_addr_in,      // Byte offset in operational space.
    input  wire logic                            reg_wr_in,         // Write strobe, one cycle.
    input  wire logic                            reg_rd_in,         // Read strobe, one cycle.
    input  wire logic [31:0]                     reg_wdata_in,      // Write data.
    output logic      [31:0]                     reg_rdata_out,     // Read data, registered.
    output logic                                 reg_rvalid_out,    // Read data valid pulse.
    // Host software legacy I/O cycles.
    input  wire logic [15:0]                     io_addr_in,        // I/O port address.
    input  wire logic                            io_wr_in,          // I/O write strobe, one cycle.
    input  wire logic                            io_rd_in,          // I/O read strobe, one cycle.
    input  wire logic [7:0]                      io_wdata_in,       // I/O write data byte.
    output logic                                 io_claim_out,      // Pulse: I/O cycle claimed by emulation.
    output logic                                 out_full_clear_out, // Pulse: clear output full flag.
    // Flags of the emulated status register, same clock domain.
    input  wire logic                            out_full_in,       // Output buffer full flag.
    input  wire logic                            aux_out_full_in,   // Auxiliary output full flag.
    // Request lines from the keyboard controller, asynchronous.
    input  wire logic                            keyboard_irq_in,   // Keyboard request, active high.
    input  wire logic                            mouse_irq_in,      // Mouse request, active high.
    // Interrupt outputs.
    output logic                                 keyboard_irq_out,  // Keyboard IRQ to the system.
    output logic                                 mouse_irq_out,     // Mouse IRQ to the system.
    output logic                                 emul_irq_out       // Emulation interrupt to software.
);
    import lkbd_pkg::*;

    // Control register fields held by software or hardware.
    logic        emulation_enable;      // Emulation on.
    logic        char_pending;          // Interrupt on output full falling.
    logic        output_irq_enable;     // Drive IRQs from output full.
    logic        external_irq_enable;   // Controller IRQs raise emulation interrupt.
    logic        gate_a20_sequence;     // Gate A20 command seen.
    logic        keyboard_irq_active;   // Keyboard request rising edge seen.
    logic        mouse_irq_active;      // Mouse request rising edge seen.
    logic        gate_a20_state;        // Current gate A20 level.

    // Internal event state.
    logic        trap_pending;          // An I/O trap awaits emulation software.
    logic        char_event;            // Output full fell while character pending.
    logic        out_full_prev;         // Output full, one cycle late.
    logic [LKBD_NUM_IRQ-1:0] irq_sync;  // Synchronised controller requests.
    logic [LKBD_NUM_IRQ-1:0] irq_prev;  // Requests one cycle late, for edges.
    logic [LKBD_NUM_IRQ-1:0] irq_rise;  // Rising edge of each request.

    // Decoded accesses.
    logic        ctrl_sel;              // Register offset hits the control register.
    logic        ctrl_wr;               // Software write of the control register.
    logic        hit_data;              // I/O cycle to the data port while enabled.
    logic        hit_cmd;               // I/O cycle to the command port while enabled.
    logic        wr_cmd_gate;           // Gate A20 command written.
    logic        wr_data_match;         // Data write that matches the A20 state in sequence.
    logic        trap_event;            // Claimed I/O cycle that needs software.
    logic        emul_int;              // Current emulation interrupt condition.
    logic [31:0] ctrl_image;            // Read image of the control register.

    // Match a 16-bit port address, used for both legacy ports.
    function automatic logic port_match(input logic [15:0] addr, input logic [15:0] port);
        port_match = (addr == port);
    endfunction : port_match

    // Request lines pass two flip-flops before any logic looks at them.
    lkbd_sync #(
        .WIDTH (LKBD_NUM_IRQ)
    ) u_irq_sync (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({mouse_irq_in, keyboard_irq_in}),
        .sync_out   (irq_sync)
    );

    // Register offset decode at the fixed control register position.
    assign ctrl_sel = (reg_addr_in == LKBD_CTRL_OFFSET);
    assign ctrl_wr  = reg_wr_in && ctrl_sel;

    // Legacy ports are only decoded while emulation is enabled.
    assign hit_data = emulation_enable && port_match(io_addr_in, LKBD_PORT_DATA);
    assign hit_cmd  = emulation_enable && port_match(io_addr_in, LKBD_PORT_CMD);

    // The gate A20 command and the matching follow-up byte are handled in hardware.
    assign wr_cmd_gate   = hit_cmd && io_wr_in && (io_wdata_in == LKBD_CMD_GATE_A20);
    assign wr_data_match = hit_data && io_wr_in && gate_a20_sequence &&
                           (io_wdata_in[LKBD_A20_DATA_BIT] == gate_a20_state);

    // Any other claimed cycle needs the emulation software.
    assign trap_event = (hit_data || hit_cmd) && (io_wr_in || io_rd_in) &&
                        !wr_cmd_gate && !wr_data_match;

    // Rising edges of the synchronised controller requests.
    assign irq_rise = irq_sync & ~irq_prev;

    // The emulation interrupt condition combines traps, character events and external requests.
    assign emul_int = (emulation_enable && (trap_pending || char_event)) ||
                      (external_irq_enable && (|irq_sync));

    // Read image; reserved bits read as zero.
    always_comb begin
        ctrl_image                       = '0;
        ctrl_image[LKBD_BIT_EMUL_EN]     = emulation_enable;
        ctrl_image[LKBD_BIT_EMUL_INT]    = emul_int;
        ctrl_image[LKBD_BIT_CHAR_PEND]   = char_pending;
        ctrl_image[LKBD_BIT_OUT_IRQ_EN]  = output_irq_enable;
        ctrl_image[LKBD_BIT_EXT_IRQ_EN]  = external_irq_enable;
        ctrl_image[LKBD_BIT_A20_SEQ]     = gate_a20_sequence;
        ctrl_image[LKBD_BIT_KBD_ACTIVE]  = keyboard_irq_active;
        ctrl_image[LKBD_BIT_MOUSE_ACT]   = mouse_irq_active;
        ctrl_image[LKBD_BIT_A20_STATE]   = gate_a20_state;
    end

    // Plain software-owned control bits; the interrupt bit ignores writes.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            emulation_enable    <= LKBD_CTRL_RESET[LKBD_BIT_EMUL_EN];
            char_pending        <= LKBD_CTRL_RESET[LKBD_BIT_CHAR_PEND];
            output_irq_enable   <= LKBD_CTRL_RESET[LKBD_BIT_OUT_IRQ_EN];
            external_irq_enable <= LKBD_CTRL_RESET[LKBD_BIT_EXT_IRQ_EN];
            gate_a20_state      <= LKBD_CTRL_RESET[LKBD_BIT_A20_STATE];
        end else if (ctrl_wr) begin
            // Bits above the defined ones are dropped; software keeps them zero.
            emulation_enable    <= reg_wdata_in[LKBD_BIT_EMUL_EN];
            char_pending        <= reg_wdata_in[LKBD_BIT_CHAR_PEND];
            output_irq_enable   <= reg_wdata_in[LKBD_BIT_OUT_IRQ_EN];
            external_irq_enable <= reg_wdata_in[LKBD_BIT_EXT_IRQ_EN];
            gate_a20_state      <= reg_wdata_in[LKBD_BIT_A20_STATE];
        end
    end

    // Gate A20 sequence bit: hardware owns it, a command port write sets or clears it.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            gate_a20_sequence <= LKBD_CTRL_RESET[LKBD_BIT_A20_SEQ];
        end else if (hit_cmd && io_wr_in) begin
            gate_a20_sequence <= (io_wdata_in == LKBD_CMD_GATE_A20);
        end else if (ctrl_wr) begin
            // Software may also rewrite it, but only when no command write competes.
            gate_a20_sequence <= reg_wdata_in[LKBD_BIT_A20_SEQ];
        end
    end

    // Keyboard active flag: a rising edge sets it and wins over a write-one clear.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            keyboard_irq_active <= LKBD_CTRL_RESET[LKBD_BIT_KBD_ACTIVE];
        end else if (irq_rise[LKBD_IDX_KBD]) begin
            keyboard_irq_active <= 1'b1;
        end else if (ctrl_wr && reg_wdata_in[LKBD_BIT_KBD_ACTIVE]) begin
            keyboard_irq_active <= 1'b0;
        end
    end

    // Mouse active flag: a rising edge sets it and wins over a write-one clear.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            mouse_irq_active <= LKBD_CTRL_RESET[LKBD_BIT_MOUSE_ACT];
        end else if (irq_rise[LKBD_IDX_MOUSE]) begin
            mouse_irq_active <= 1'b1;
        end else if (ctrl_wr && reg_wdata_in[LKBD_BIT_MOUSE_ACT]) begin
            mouse_irq_active <= 1'b0;
        end
    end

    // Request history for edge detection, taken from the synchronised levels only.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            irq_prev <= '0;
        end else begin
            irq_prev <= irq_sync;
        end
    end

    // Output full history, to spot the moment the flag falls.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            out_full_prev <= 1'b0;
        end else begin
            out_full_prev <= out_full_in;
        end
    end

    // Trap pending: set by a claimed cycle that needs software, cleared by a control write; the set wins.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            trap_pending <= 1'b0;
        end else if (trap_event) begin
            trap_pending <= 1'b1;
        end else if (ctrl_wr || !emulation_enable) begin
            trap_pending <= 1'b0;
        end
    end

    // Character event: output full falling while character pending; a control write clears it.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            char_event <= 1'b0;
        end else if (char_pending && out_full_prev && !out_full_in) begin
            char_event <= 1'b1;
        end else if (ctrl_wr || !char_pending) begin
            char_event <= 1'b0;
        end
    end

    // Claim and side-effect pulses for the legacy I/O cycle, one cycle after the strobe.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            io_claim_out       <= 1'b0;
            out_full_clear_out <= 1'b0;
        end else begin
            io_claim_out       <= (hit_data || hit_cmd) && (io_wr_in || io_rd_in);
            out_full_clear_out <= hit_data && io_rd_in;
        end
    end

    // System IRQ outputs: output-full driven request or a latched controller edge.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            keyboard_irq_out <= 1'b0;
            mouse_irq_out    <= 1'b0;
        end else begin
            keyboard_irq_out <= emulation_enable &&
                                ((output_irq_enable && out_full_in && !aux_out_full_in) ||
                                 keyboard_irq_active);
            mouse_irq_out    <= emulation_enable &&
                                ((output_irq_enable && out_full_in && aux_out_full_in) ||
                                 mouse_irq_active);
        end
    end

    // Emulation interrupt output follows the current condition one cycle late.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            emul_irq_out <= 1'b0;
        end else begin
            emul_irq_out <= emul_int;
        end
    end

    // Register read path: data and valid one cycle after the strobe; other offsets read zero.
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out  <= '0;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in && ctrl_sel) begin
                reg_rdata_out <= ctrl_image;
            end else begin
                reg_rdata_out <= '0;
            end
        end
    end

endmodule : lkbd_ctrl

/* File: tb/lkbd_kbc_model.sv */
`timescale 1ns/10ps
// Keyboard controller and emulation software side: request lines and status flags.
module lkbd_kbc_model (
    input  wire logic       mclk_in,           // Host controller clock.
    input  wire logic       fill_in,           // Software places a byte in the output buffer.
    input  wire logic       drain_in,          // Software withdraws the byte itself.
    input  wire logic       aux_in,            // The pending byte belongs to the mouse.
    input  wire logic [1:0] req_in,            // Requests to raise: keyboard in bit 0, mouse in bit 1.
    input  wire logic       out_full_clear_in, // A claimed port read consumed the byte.
    output logic            out_full_out,      // Output buffer full flag.
    output logic            aux_out_full_out,  // Auxiliary output full flag.
    output logic            keyboard_irq_out,  // Keyboard request line.
    output logic            mouse_irq_out      // Mouse request line.
);
    // Flags and request lines all start idle, since the controller has no reset pin here.
    initial begin
        out_full_out = 1'b0;
        aux_out_full_out = 1'b0;
        keyboard_irq_out = 1'b0;
        mouse_irq_out = 1'b0;
    end
    // Everything changes just after an edge; a port read empties the buffer as the device asks.
    always @(posedge mclk_in) begin
        if (fill_in) begin
            out_full_out <= 1'b1;
        end else if (drain_in || out_full_clear_in) begin
            out_full_out <= 1'b0;
        end
        aux_out_full_out <= aux_in;
        keyboard_irq_out <= req_in[0];
        mouse_irq_out <= req_in[1];
    end
endmodule : lkbd_kbc_model

/* File: tb/lkbd_ctrl_chk.sv */
`timescale 1ns/10ps
// Checker beside the emulation control block; it sees only the block's ports.
module lkbd_ctrl_chk
    import lkbd_pkg::*;
(
    input wire logic                             mclk_in,
    input wire logic                             reset_n_in,
    input wire logic [lkbd_pkg::LKBD_ADDR_W-1:0] reg_addr_in,
    input wire logic                             reg_wr_in,
    input wire logic                             reg_rd_in,
    input wire logic [31:0]                      reg_wdata_in,
    input wire logic [31:0]                      reg_rdata_out,
    input wire logic                             reg_rvalid_out,
    input wire logic [15:0]                      io_addr_in,
    input wire logic                             io_wr_in,
    input wire logic                             io_rd_in,
    input wire logic [7:0]                       io_wdata_in,
    input wire logic                             io_claim_out,
    input wire logic                             out_full_clear_out,
    input wire logic                             out_full_in,
    input wire logic                             aux_out_full_in,
    input wire logic                             keyboard_irq_in,
    input wire logic                             mouse_irq_in,
    input wire logic                             keyboard_irq_out,
    input wire logic                             mouse_irq_out,
    input wire logic                             emul_irq_out
);
    logic en_q;   // Shadow of the enable bit.
    logic oirq_q; // Shadow of the output IRQ enable bit.
    logic ext_q;  // Shadow of the external IRQ enable bit.
    logic rst_q;  // Reset was active at the previous edge.
    logic ctl_hit; // Register access aimed at the control register.
    logic io_hit;  // I/O cycle to one of the two decoded ports.
    assign ctl_hit = (reg_addr_in == LKBD_CTRL_OFFSET);
    assign io_hit = (io_wr_in || io_rd_in) && (io_addr_in == LKBD_PORT_DATA || io_addr_in == LKBD_PORT_CMD);
    // The shadows follow software writes so the checks know which enables are on.
    always_ff @(posedge mclk_in) begin
        rst_q <= !reset_n_in;
        if (!reset_n_in) begin
            en_q <= 1'b0;
            oirq_q <= 1'b0;
            ext_q <= 1'b0;
        end else if (reg_wr_in && ctl_hit) begin
            en_q <= reg_wdata_in[LKBD_BIT_EMUL_EN];
            oirq_q <= reg_wdata_in[LKBD_BIT_OUT_IRQ_EN];
            ext_q <= reg_wdata_in[LKBD_BIT_EXT_IRQ_EN];
        end
    end
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);
    chk_reset_quiet: assert property (rst_q |-> reg_rdata_out == 32'h0 && !keyboard_irq_out && !mouse_irq_out
        && !emul_irq_out) else $error("outputs active after reset");
    chk_read_reserved: assert property (reg_rd_in |=> reg_rvalid_out && reg_rdata_out[31:9] == 23'h0)
        else $error("read answer missing or reserved bits set");
    chk_unmapped_zero: assert property (reg_rd_in && !ctl_hit |=> reg_rdata_out == 32'h0)
        else $error("unmapped offset read nonzero");
    chk_status_mirror: assert property (reg_rd_in && ctl_hit |=> reg_rdata_out[1] == emul_irq_out)
        else $error("interrupt bit differs from interrupt output");
    chk_port_claim: assert property (en_q && io_hit |=> io_claim_out) else $error("decoded port not claimed");
    chk_claim_off: assert property (!en_q |=> !io_claim_out && !out_full_clear_out && !keyboard_irq_out
        && !mouse_irq_out) else $error("activity while emulation disabled");
    chk_full_clear: assert property (en_q && io_rd_in && io_addr_in == LKBD_PORT_DATA |=> out_full_clear_out)
        else $error("data port read did not clear output full");
    chk_kbd_drive: assert property (en_q && oirq_q && out_full_in && !aux_out_full_in |=> keyboard_irq_out)
        else $error("keyboard irq not driven while output full");
    chk_mouse_drive: assert property (en_q && oirq_q && out_full_in && aux_out_full_in |=> mouse_irq_out)
        else $error("mouse irq not driven while aux output full");
    chk_ext_irq: assert property ((ext_q && keyboard_irq_in)[*4] |-> ##[0:2] emul_irq_out)
        else $error("external request raised no emulation interrupt");
endmodule : lkbd_ctrl_chk

bind lkbd_ctrl lkbd_ctrl_chk chk (.*);

/* File: tb/lkbd_ctrl_bench.sv */
`timescale 1ns/10ps
// Self-checking bench: register and port cycles with the controller model on the far side.
module lkbd_ctrl_bench;
    import lkbd_pkg::*;
    logic                   mclk_in = 1'b0;      // Host controller clock.
    logic                   reset_n_in = 1'b0;   // Reset, active low.
    logic [LKBD_ADDR_W-1:0] reg_addr_in = 12'h0; // Register offset.
    logic [31:0]            reg_wdata_in = 32'h0; // Register write data.
    logic [15:0]            io_addr_in = 16'h0;  // Legacy port address.
    logic [7:0]             io_wdata_in = 8'h0;  // Legacy port write byte.
    logic                   reg_wr_in = 1'b0, reg_rd_in = 1'b0, io_wr_in = 1'b0, io_rd_in = 1'b0;
    logic                   fill = 1'b0, drain = 1'b0, aux = 1'b0; // Commands to the model.
    logic [1:0]             req = 2'h0;          // Request levels asked of the model.
    logic [31:0]            reg_rdata_out;
    logic                   reg_rvalid_out, io_claim_out, out_full_clear_out, keyboard_irq_out, mouse_irq_out;
    logic                   emul_irq_out, out_full_in, aux_out_full_in, keyboard_irq_in, mouse_irq_in;
    int                     fail_count = 0;      // Mismatches seen.
    int                     tests_run = 0;       // Comparisons made.
    wire [4:0] obs = {io_claim_out, out_full_clear_out, mouse_irq_out, keyboard_irq_out, emul_irq_out};
    always #25 mclk_in = ~mclk_in;
    lkbd_ctrl dut (.*);
    lkbd_kbc_model kbc (.mclk_in(mclk_in), .fill_in(fill), .drain_in(drain), .aux_in(aux), .req_in(req),
        .out_full_clear_in(out_full_clear_out), .out_full_out(out_full_in), .aux_out_full_out(aux_out_full_in),
        .keyboard_irq_out(keyboard_irq_in), .mouse_irq_out(mouse_irq_in));
    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Writes the control register; every task but check starts and ends just after a rising edge.
    task automatic reg_write(input logic [31:0] d);
        reg_addr_in <= LKBD_CTRL_OFFSET;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask : reg_write
    // Reads one offset and compares the masked answer.
    task automatic reg_expect(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(negedge mclk_in);
        check(n, reg_rdata_out & m, e);
        @(posedge mclk_in);
    endtask : reg_expect
    // One legacy port cycle, write or read.
    task automatic io_acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        io_addr_in <= a;
        io_wdata_in <= d;
        io_wr_in <= wr;
        io_rd_in <= !wr;
        @(posedge mclk_in);
        io_wr_in <= 1'b0;
        io_rd_in <= 1'b0;
    endtask : io_acc
    // Asks the model to fill or drain the output buffer.
    task automatic set_full(input logic v);
        fill <= v;
        drain <= !v;
        @(posedge mclk_in);
        fill <= 1'b0;
        drain <= 1'b0;
    endtask : set_full
    // Waits a fixed latency, then compares one observed output mid-cycle.
    task automatic look(input string n, input int idx, input logic e, input int cyc);
        repeat (cyc) @(posedge mclk_in);
        @(negedge mclk_in);
        check(n, obs[idx], e);
        @(posedge mclk_in);
    endtask : look
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge mclk_in);
        fail_count++;
        print_verdict();
    end
    // Main sequence of scenarios.
    initial begin
        repeat (3) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        reg_expect("ctrl reset", LKBD_CTRL_OFFSET, 32'hffff_ffff, LKBD_CTRL_RESET);
        reg_expect("unmapped", 12'h104, 32'hffff_ffff, 32'h0);
        reg_write(32'h0000_01ff);
        reg_expect("ctrl image", LKBD_CTRL_OFFSET, 32'hffff_ffff, 32'h0000_013d);
        reg_write(32'h0000_0001);
        io_acc(1'b1, LKBD_PORT_CMD, LKBD_CMD_GATE_A20);
        look("claim", 4, 1'b1, 0);
        reg_expect("sequence set", LKBD_CTRL_OFFSET, 32'h20, 32'h20);
        io_acc(1'b1, LKBD_PORT_CMD, 8'h00);
        reg_expect("sequence clear", LKBD_CTRL_OFFSET, 32'h20, 32'h0);
        look("trap irq", 0, 1'b1, 1);
        for (int i = 0; i < 2; i++) begin
            reg_write(32'h0000_0101);
            io_acc(1'b1, LKBD_PORT_CMD, LKBD_CMD_GATE_A20);
            // One idle edge so the write strobe is not lowered and raised in one step.
            @(posedge mclk_in);
            io_acc(1'b1, LKBD_PORT_DATA, (i == 0) ? 8'h02 : 8'h00);
            look("a20 compare", 0, i[0], 1);
        end
        // Sequence bit left set with emulation off; an undecoded command write must not clear it.
        reg_write(32'h20);
        io_acc(1'b1, LKBD_PORT_CMD, 8'h00);
        look("no claim", 4, 1'b0, 0);
        reg_expect("sequence ignored", LKBD_CTRL_OFFSET, 32'h20, 32'h20);
        for (int i = 0; i < 2; i++) begin
            reg_write((i == 0) ? 32'h5 : 32'h1);
            set_full(1'b1);
            // One idle edge so the model commands are not lowered and raised in one step.
            @(posedge mclk_in);
            set_full(1'b0);
            look("char pending", 0, !i[0], 3);
        end
        set_full(1'b1);
        io_acc(1'b0, LKBD_PORT_DATA, 8'h00);
        look("full clear", 3, 1'b1, 0);
        reg_write(32'h9);
        set_full(1'b1);
        for (int a = 0; a < 2; a++) begin
            aux <= a[0];
            look("kbd out irq", 1, !a[0], 3);
            look("mouse out irq", 2, a[0], 0);
        end
        set_full(1'b0);
        look("irq drop", 2, 1'b0, 3);
        reg_write(32'h1);
        for (int j = 0; j < 2; j++) begin
            req[j] <= 1'b1;
            look("controller irq", 1 + j, 1'b1, 5);
            req[j] <= 1'b0;
            reg_expect("active flag", LKBD_CTRL_OFFSET, 32'h40 << j, 32'h40 << j);
            reg_write(32'h1 | (32'h40 << j));
            look("flag cleared", 1 + j, 1'b0, 1);
        end
        reg_write(32'h10);
        req[0] <= 1'b1;
        look("external irq", 0, 1'b1, 5);
        req[0] <= 1'b0;
        look("external idle", 0, 1'b0, 5);
        print_verdict();
    end
endmodule : lkbd_ctrl_bench
